// ---- plcdt_panel_model.sv ----
// receive-only panel model: measures line, frame and shift timing
// assumes the panel struct is sampled on the device's own clock
`timescale 1ns/1ps
module plcdt_panel_model (
  input wire logic clk,
  input wire logic resetn,
  input wire plcdt_pkg::plcdt_panel_s panel,
  output logic [15:0] lines_q,
  output logic [15:0] lclk_q,
  output logic [15:0] spl_q,
  output logic [15:0] line_n,
  output logic cap_v,
  output logic [7:0] cap_d
);
  logic lp_q, sh_q, fp_q;
  logic [15:0] lc, cc, sc;
  // a panel latches data on the shift fall, so capture it there
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {lp_q, sh_q, fp_q, cap_v, cap_d} <= '0;
      {lines_q, lclk_q, spl_q, line_n, lc, cc, sc} <= '0;
    end else begin
      lp_q <= panel.line_pulse;
      sh_q <= panel.shift_clock;
      fp_q <= panel.frame_pulse;
      cap_v <= sh_q && !panel.shift_clock;
      cap_d <= panel.panel_data;
      cc <= cc + 16'h1;
      if (panel.shift_clock && !sh_q)
        sc <= sc + 16'h1;
      if (panel.line_pulse && !lp_q) begin
        line_n <= line_n + 16'h1;
        lc <= lc + 16'h1;
        lclk_q <= cc;
        cc <= 16'h1;
        sc <= 16'h0;
        if (sc != 16'h0)
          spl_q <= sc; // lines without shifts leave spl_q unchanged
      end
      if (panel.frame_pulse && !fp_q) begin
        lines_q <= lc;
        lc <= 16'h0;
      end
    end
  end
endmodule : plcdt_panel_model

// ---- plcdt_pkg.sv ----
// constants, types and register layout for the passive panel timing block
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register slave
// Operation
// - enabling the display starts all panel signals within one frame period
// - panel power enable rises together with the panel signals at power-on
// - override set: save stops signals within a frame, release restarts them
// - override clear: save makes signals inactive within one frame
// - software power-down drops power, runs signals 127 more frames, then stops
// - override clear: save release restarts signals and power together
// - override set drops power enable, override clear raises it again
// - displayed lines per frame are the 10-bit line field plus one
// - vertical blank lines per frame equal the 6-bit blank field; the code still shifts data and raises display_ready_signal on them
// - horizontal display lasts eight pixels times the 7-bit field plus one
// - horizontal blank lasts at least eight pixels times the field plus four
// - line period is at least display count plus blank count times eight
// - frame pulse held 9 pixels after line fall, set up a line earlier
// - line pulse stays high at least 9 pixel periods
// - modulation output changes one pixel after the line pulse rises
// - mono 4-bit: upper nibble, shift period 4, 2 low 2 high
// - mono 8-bit: all eight lines, shift period 8, 4 low 4 high
// - colour 4-bit: upper nibble, shift period one pixel, half each
// - first shift rise at least 23 (mono) or 24 (colour) after line fall
// - first shift fall after line fall delayed by rise margin plus half period
// - last shift fall to line rise at least eight times blank plus 2 or 4
// - last shift fall to line fall is eight times blank plus 13
package plcdt_pkg;

  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h3;
  localparam logic [3:0] IDX_HDISP = 4'h4;
  localparam logic [3:0] IDX_VDISP_LO = 4'h5;
  localparam logic [3:0] IDX_VDISP_HI = 4'h6;
  localparam logic [3:0] IDX_HBLANK = 4'h8;
  localparam logic [3:0] IDX_VBLANK = 4'hA;
  localparam logic [3:0] IDX_STATUS = 4'hB;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_OVERRIDE_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [6:0] HDISP_RST = 7'h27;
  localparam logic [7:0] VDISP_LO_RST = 8'hEF;
  localparam logic [1:0] VDISP_HI_RST = 2'h0;
  localparam logic [4:0] HBLANK_RST = 5'h00;
  localparam logic [5:0] VBLANK_RST = 6'h00;

  // horizontal timing, in pixel periods
  localparam logic [10:0] H_ONE = 11'h001;
  localparam logic [10:0] HBLANK_BASE = 11'h020;
  localparam logic [10:0] H_PAD = 11'h008;
  localparam logic [10:0] LP_LEAD = 11'h004;
  localparam logic [10:0] LP_WIDTH = 11'h009;
  localparam logic [10:0] FP_HOLD = 11'h009;

  // power-down drain length in frames
  localparam int DRAIN_FRAMES_DEF = 127;

  typedef enum logic [1:0] {MODE_MONO4, MODE_MONO8, MODE_COLOR4} plcdt_mode_e;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DRAIN, ST_SAVE} plcdt_pwr_e;

  typedef struct packed {
    logic line_pulse;
    logic frame_pulse;
    logic shift_clock;
    logic [7:0] panel_data;
    logic display_ready_signal;
    logic ac_modulation;
  } plcdt_panel_s;

endpackage : plcdt_pkg

// ---- plcdt_timing.sv ----
// panel timing generator with power sequencing and Avalon-MM registers
// assumes pixel data arrives from same-clock logic on pixel_req,
// and hardware_power_save comes from a pin in another domain
`timescale 1ns/1ps

module plcdt_timing #(
  parameter int PIX_DIV = 2,
  parameter int DRAIN_FRAMES = plcdt_pkg::DRAIN_FRAMES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hardware_power_save,
  input wire logic [7:0] pixel_in,
  output logic pixel_req,
  output plcdt_pkg::plcdt_panel_s panel,
  output logic panel_power_enable
);

  localparam int HALF = PIX_DIV / 2;

  // register file
  logic [3:0] ctrl_q;
  logic [6:0] hdisp_q;
  logic [7:0] vdisp_lo_q;
  logic [1:0] vdisp_hi_q;
  logic [4:0] hblank_q;
  logic [5:0] vblank_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic wr_ok;

  // synchroniser and power state
  logic hps_meta_q;
  logic hps_q;
  plcdt_pkg::plcdt_pwr_e state_q;
  logic [7:0] drain_q;
  logic run_active;
  logic enable;
  logic override;
  plcdt_pkg::plcdt_mode_e mode;

  // pixel enable and counters
  logic [7:0] half_cnt_q;
  logic half_ph_q;
  logic half_en;
  logic pix_en;
  logic [10:0] h_q;
  logic [10:0] v_q;
  logic [10:0] h_next;
  logic [10:0] hd_w;
  logic [10:0] hn_w;
  logic [10:0] line_total;
  logic [10:0] lp_rise;
  logic [10:0] lp_fall;
  logic [10:0] v_last;
  logic line_end;
  logic frame_end;

  // panel signal generation
  logic load;
  logic [7:0] data_q;
  logic mod_q;
  logic win;
  logic sc;
  logic fp;
  logic pwr_q;
  plcdt_pkg::plcdt_panel_s panel_q;

  assign enable = ctrl_q[plcdt_pkg::CTRL_ENABLE_BIT];
  assign override = ctrl_q[plcdt_pkg::CTRL_OVERRIDE_BIT];

  // mode code 3 is unused and falls back to mono 4-bit
  always_comb begin
    case (ctrl_q[plcdt_pkg::CTRL_MODE_LSB +: 2])
      2'h1: mode = plcdt_pkg::MODE_MONO8;
      2'h2: mode = plcdt_pkg::MODE_COLOR4;
      default: mode = plcdt_pkg::MODE_MONO4;
    endcase
  end

  // bus handshake: one wait cycle, then the request is taken
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_ok = avs_write & ack_q & avs_byteenable[0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // register writes; only byte lane 0 carries fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= plcdt_pkg::CTRL_RST;
      hdisp_q <= plcdt_pkg::HDISP_RST;
      vdisp_lo_q <= plcdt_pkg::VDISP_LO_RST;
      vdisp_hi_q <= plcdt_pkg::VDISP_HI_RST;
      hblank_q <= plcdt_pkg::HBLANK_RST;
      vblank_q <= plcdt_pkg::VBLANK_RST;
    end else if (wr_ok) begin
      case (avs_address)
        plcdt_pkg::IDX_CTRL: ctrl_q <= avs_writedata[3:0];
        plcdt_pkg::IDX_HDISP: hdisp_q <= avs_writedata[6:0];
        plcdt_pkg::IDX_VDISP_LO: vdisp_lo_q <= avs_writedata[7:0];
        plcdt_pkg::IDX_VDISP_HI: vdisp_hi_q <= avs_writedata[1:0];
        plcdt_pkg::IDX_HBLANK: hblank_q <= avs_writedata[4:0];
        plcdt_pkg::IDX_VBLANK: vblank_q <= avs_writedata[5:0];
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // read mux, unmapped and reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      plcdt_pkg::IDX_CTRL: rd_mux[3:0] = ctrl_q;
      plcdt_pkg::IDX_HDISP: rd_mux[6:0] = hdisp_q;
      plcdt_pkg::IDX_VDISP_LO: rd_mux[7:0] = vdisp_lo_q;
      plcdt_pkg::IDX_VDISP_HI: rd_mux[1:0] = vdisp_hi_q;
      plcdt_pkg::IDX_HBLANK: rd_mux[4:0] = hblank_q;
      plcdt_pkg::IDX_VBLANK: rd_mux[5:0] = vblank_q;
      plcdt_pkg::IDX_STATUS: begin
        rd_mux[0] = run_active;
        rd_mux[1] = pwr_q;
        rd_mux[2] = hps_q;
        rd_mux[3] = (state_q == plcdt_pkg::ST_DRAIN);
        rd_mux[4] = (state_q == plcdt_pkg::ST_SAVE);
        rd_mux[15:8] = drain_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, valid at the taking edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;

  // two-flop synchroniser for the power-save pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hps_meta_q <= 1'b0;
      hps_q <= 1'b0;
    end else begin
      hps_meta_q <= hardware_power_save;
      hps_q <= hps_meta_q;
    end
  end

  // pixel enable from a half-pixel divider; colour shift needs half phases
  assign half_en = (half_cnt_q == 8'(HALF - 1));
  assign pix_en = half_en & half_ph_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_q <= 8'h00;
      half_ph_q <= 1'b0;
    end else if (!run_active) begin
      half_cnt_q <= 8'h00;
      half_ph_q <= 1'b0;
    end else if (half_en) begin
      half_cnt_q <= 8'h00;
      half_ph_q <= ~half_ph_q;
    end else begin
      half_cnt_q <= half_cnt_q + 8'h01;
    end
  end

  // line geometry in pixel periods
  assign hd_w = 11'(({4'h0, hdisp_q} + plcdt_pkg::H_ONE) << 3);
  // extra pad keeps the line-start margin for every format
  assign hn_w = {3'h0, hblank_q, 3'h0} + plcdt_pkg::HBLANK_BASE
              + plcdt_pkg::H_PAD;
  assign line_total = hd_w + hn_w;
  assign lp_rise = hd_w + {3'h0, hblank_q, 3'h0} + plcdt_pkg::LP_LEAD;
  assign lp_fall = lp_rise + plcdt_pkg::LP_WIDTH;
  assign v_last = {1'b0, vdisp_hi_q, vdisp_lo_q} + {5'h00, vblank_q};

  // wrap on >= so a shrinking register mid-line cannot run away
  assign line_end = (h_q >= line_total - plcdt_pkg::H_ONE);
  assign frame_end = pix_en & line_end & (v_q >= v_last);
  assign h_next = line_end ? 11'h000 : h_q + plcdt_pkg::H_ONE;

  // horizontal and vertical counters run only while signals are active
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_q <= 11'h000;
      v_q <= 11'h000;
    end else if (!run_active) begin
      h_q <= 11'h000;
      v_q <= 11'h000;
    end else if (pix_en) begin
      h_q <= h_next;
      if (line_end) begin
        v_q <= (v_q >= v_last) ? 11'h000 : v_q + plcdt_pkg::H_ONE;
      end
    end
  end

  // power sequencing; stops wait for the frame end, so they land in a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= plcdt_pkg::ST_OFF;
      drain_q <= 8'h00;
    end else begin
      case (state_q)
        plcdt_pkg::ST_OFF: begin
          drain_q <= 8'h00;
          if (enable && !hps_q) begin
            state_q <= plcdt_pkg::ST_RUN;
          end
        end
        plcdt_pkg::ST_RUN: begin
          drain_q <= 8'h00;
          if (hps_q && frame_end) begin
            state_q <= plcdt_pkg::ST_SAVE;
          end else if (!enable && !hps_q) begin
            state_q <= plcdt_pkg::ST_DRAIN;
          end
        end
        plcdt_pkg::ST_DRAIN: begin
          if (enable && !hps_q) begin
            state_q <= plcdt_pkg::ST_RUN;
          end else if (frame_end && hps_q) begin
            state_q <= plcdt_pkg::ST_SAVE;
          end else if (frame_end) begin
            if (drain_q == 8'(DRAIN_FRAMES - 1)) begin
              state_q <= plcdt_pkg::ST_OFF;
            end
            drain_q <= drain_q + 8'h01;
          end
        end
        plcdt_pkg::ST_SAVE: begin
          if (!hps_q) begin
            // signals come back if enable is set, and power with them unless override is set, on the same edge
            state_q <= enable ? plcdt_pkg::ST_RUN
                              : plcdt_pkg::ST_OFF;
          end
        end
        default: state_q <= plcdt_pkg::ST_OFF;
      endcase
    end
  end

  assign run_active = (state_q == plcdt_pkg::ST_RUN)
                    | (state_q == plcdt_pkg::ST_DRAIN);

  // power drops at once on save or override, no frame wait needed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= (state_q == plcdt_pkg::ST_RUN) & ~override & ~hps_q;
    end
  end

  assign panel_power_enable = pwr_q;

  // fetch a new word at each shift rising edge inside the display window, except the first colour shift after start
  always_comb begin
    load = 1'b0;
    if (run_active && pix_en && h_next < hd_w) begin
      case (mode)
        plcdt_pkg::MODE_MONO8: load = (h_next[2:0] == 3'h4);
        plcdt_pkg::MODE_COLOR4: load = 1'b1;
        default: load = (h_next[1:0] == 2'h2);
      endcase
    end
  end

  assign pixel_req = load;

  // data changes mid-period, giving equal setup and hold at the fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= 8'h00;
    end else if (!run_active) begin
      data_q <= 8'h00;
    end else if (load) begin
      if (mode == plcdt_pkg::MODE_MONO8) begin
        data_q <= pixel_in;
      end else begin
        data_q <= {pixel_in[3:0], 4'h0};
      end
    end
  end

  // modulation toggles one pixel after the line pulse rises
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mod_q <= 1'b0;
    end else if (!run_active) begin
      mod_q <= 1'b0;
    end else if (pix_en && h_q == lp_rise) begin
      mod_q <= ~mod_q;
    end
  end

  // shift clock shape per format; window starts at h zero
  assign win = (h_q < hd_w);
  always_comb begin
    case (mode)
      plcdt_pkg::MODE_MONO8: sc = win & h_q[2];
      plcdt_pkg::MODE_COLOR4: sc = win & ~half_ph_q;
      default: sc = win & h_q[1];
    endcase
  end

  // frame pulse spans last line's line fall to line 0's fall plus hold
  assign fp = ((v_q == v_last) && (h_q >= lp_fall))
            | ((v_q == 11'h000) && (h_q < lp_fall + plcdt_pkg::FP_HOLD));

  // all panel outputs share one register stage so edges stay aligned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      panel_q <= '0;
    end else if (!run_active) begin
      panel_q <= '0;
    end else begin
      panel_q.line_pulse <= (h_q >= lp_rise) && (h_q < lp_fall);
      panel_q.frame_pulse <= fp;
      panel_q.shift_clock <= sc;
      panel_q.panel_data <= data_q;
      panel_q.display_ready_signal <= win;
      panel_q.ac_modulation <= mod_q;
    end
  end

  assign panel = panel_q;

endmodule : plcdt_timing

// ---- plcdt_timing_asserts.sv ----
// port-level checker for panel timing and power sequencing
// assumes registers are rewritten only while the panel is idle
`timescale 1ns/1ps
module plcdt_timing_asserts #(
  parameter int PIX_DIV = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire plcdt_pkg::plcdt_panel_s panel,
  input wire logic panel_power_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic lp, sh, lp_q, sh_q, wok, m8, c4;
  logic [1:0] md_q;
  logic [4:0] hb_q;
  logic [15:0] lf_n, sf_n, lh_n, sh_n;
  int hb8, hw;
  assign lp = panel.line_pulse;
  assign sh = panel.shift_clock;
  assign wok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign m8 = md_q == 2'h1;
  assign c4 = md_q == 2'h2;
  assign hb8 = 8 * hb_q;
  assign hw = c4 ? PIX_DIV / 2 : m8 ? 4 * PIX_DIV : 2 * PIX_DIV;
  // mirror of mode and blank fields from accepted writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      md_q <= 2'h0;
      hb_q <= 5'h00;
    end else if (wok && avs_address == plcdt_pkg::IDX_CTRL) begin
      md_q <= avs_writedata[3:2];
    end else if (wok && avs_address == plcdt_pkg::IDX_HBLANK) begin
      hb_q <= avs_writedata[4:0];
    end
  end
  // distance counters saturate so a cold start reads as far away
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {lp_q, sh_q} <= 2'h0;
      {lf_n, sf_n} <= 32'hFFFFFFFF;
      {lh_n, sh_n} <= 32'h0;
    end else begin
      lp_q <= lp;
      sh_q <= sh;
      lf_n <= (lp_q && !lp) ? 16'h1 : lf_n + 16'(lf_n != 16'hFFFF);
      sf_n <= (sh_q && !sh) ? 16'h1 : sf_n + 16'(sf_n != 16'hFFFF);
      lh_n <= lp ? lh_n + 16'h1 : 16'h0;
      sh_n <= sh ? sh_n + 16'h1 : 16'h0;
    end
  end
  line_width_a: assert property (lp_q && !lp |-> lh_n == 9 * PIX_DIV)
    else $error("line pulse width wrong");
  frame_hold_a: assert property ($fell(panel.frame_pulse) |->
    lf_n >= 9 * PIX_DIV) else $error("frame hold too short");
  // delays below are for the two-clock pixel used here
  mod_delay_a: assert property (lp && !lp_q |->
    ##1 $stable(panel.ac_modulation) ##1 $changed(panel.ac_modulation))
    else $error("modulation not one pixel after line rise");
  shift_high_a: assert property (sh_q && !sh |-> sh_n == hw)
    else $error("shift high width wrong");
  shift_low_a: assert property (sh && !sh_q |-> sf_n >= hw)
    else $error("shift low width short");
  first_shift_a: assert property (sh && !sh_q |->
    lf_n >= (c4 ? 24 : 23) * PIX_DIV) else $error("shift rise too early");
  shift_fall_a: assert property (sh_q && !sh |->
    2 * lf_n >= (c4 ? 49 : m8 ? 54 : 50) * PIX_DIV)
    else $error("shift fall too early");
  blank_rise_a: assert property (!c4 && lp && !lp_q |->
    sf_n >= (hb8 + (m8 ? 4 : 2)) * PIX_DIV) else $error("line rise early");
  blank_fall_a: assert property (!c4 && lp_q && !lp |->
    sf_n >= (hb8 + (m8 ? 13 : 11)) * PIX_DIV) else $error("line fall early");
  data_nibble_a: assert property (sh && !m8 |->
    panel.panel_data[3:0] == 4'h0) else $error("low nibble not zero");
  ovr_power_a: assert property (wok && avs_address == plcdt_pkg::IDX_CTRL &&
    avs_writedata[1] |-> ##[1:8] !panel_power_enable)
    else $error("power stayed on under override");
  power_up_a: assert property ($rose(panel_power_enable) |->
    ##[0:1000] panel.display_ready_signal) else $error("power without signals");
  colour_c: cover property (c4 && sh && !sh_q);
  frame_c: cover property ($fell(panel.frame_pulse));
  power_c: cover property ($fell(panel_power_enable));
endmodule : plcdt_timing_asserts

bind plcdt_timing plcdt_timing_asserts #(.PIX_DIV(PIX_DIV)) chk (
  .clk(clk),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest),
  .panel(panel),
  .panel_power_enable(panel_power_enable)
);

// ---- plcdt_timing_tb_top.sv ----
// bench: registers, all panel formats, power-down and override paths
// assumes the checker bind and panel model are compiled before it
`timescale 1ns/1ps
module plcdt_timing_tb_top;
  localparam int FRM = 768; // 6 lines of 64 pixels, two clocks each
  localparam logic [3:0] RI [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'h1};
  localparam logic [7:0] RV [7] = '{8'h0, 8'h27, 8'hEF, 8'h0, 8'h0, 8'h0, 8'h0};
  logic clk, resetn, avs_read, avs_write, pixel_req, ppe, hps, ok, cap_v;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic avs_waitrequest;
  logic [7:0] pixel_in, cap_d;
  logic [15:0] lines_q, lclk_q, spl_q, line_n, l0;
  logic [1:0] cur_mode;
  plcdt_pkg::plcdt_panel_s panel;
  logic [31:0] rq[$];
  logic [7:0] dq[$];
  int bad_count = 0;
  int n_tests = 0;
  plcdt_timing #(.PIX_DIV(2), .DRAIN_FRAMES(2)) dut (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hardware_power_save(hps), .pixel_in(pixel_in),
    .pixel_req(pixel_req), .panel(panel), .panel_power_enable(ppe));
  plcdt_panel_model pm (
    .clk(clk), .resetn(resetn), .panel(panel), .lines_q(lines_q),
    .lclk_q(lclk_q), .spl_q(spl_q), .line_n(line_n),
    .cap_v(cap_v), .cap_d(cap_d));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) bad_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic wait_line(input int lim);
    ok = 1'b0;
    l0 = line_n;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      ok = line_n != l0;
    end
  endtask : wait_line
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // random pixels; each taken word is noted as the expected lane value
  always @(posedge clk) begin
    if (pixel_req === 1'b1)
      dq.push_back(cur_mode == 2'h1 ? pixel_in : {pixel_in[3:0], 4'h0});
    seed = lfsr(seed);
    pixel_in <= seed[7:0];
  end
  // results are matched against the oldest note as they appear
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, rq.size() ? rq.pop_front() : 'x);
    if (cap_v === 1'b1)
      check(cap_d, dq.size() ? dq.pop_front() : 'x);
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {resetn, avs_read, avs_write, hps} = 4'h0;
    {avs_address, avs_byteenable, cur_mode} = 10'h0;
    avs_writedata = 32'h0;
    seed = 32'h0EF6;
    pixel_in = 8'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (RI[i]) rd(RI[i], {24'h0, RV[i]});
    bus(1'b1, 4'h1, 32'hFF, 4'hF); // unmapped index
    bus(1'b1, 4'h4, 32'h7F, 4'h0); // lane 0 disabled, dropped
    rd(4'h1, 32'h0);
    rd(4'h4, 32'h27);
    wr(4'h4, 32'h1);
    wr(4'h5, 32'h3);
    wr(4'h8, 32'h1);
    wr(4'hA, 32'h2);
    rd(4'h8, 32'h1);
    // every format, then software power-down with its drain
    for (int m = 0; m < 4; m++) begin
      cur_mode = m[1:0];
      dq.delete();
      // colour shifts at h zero before any fetch, so the cleared word leads
      if (cur_mode == 2'h2) dq.push_back(8'h00);
      wr(4'h3, {28'h0, cur_mode, 2'h1});
      wait_line(FRM);
      check(ok, 1'b1);
      check(ppe, 1'b1);
      repeat (2 * FRM) @(posedge clk);
      check(lines_q, 16'h6);
      check(lclk_q, 16'h80);
      check(spl_q, m == 1 ? 16'h2 : m == 2 ? 16'h10 : 16'h4);
      wr(4'h3, {28'h0, cur_mode, 2'h0});
      repeat (4) @(posedge clk);
      check(ppe, 1'b0);
      l0 = line_n;
      repeat (FRM / 2) @(posedge clk);
      check(line_n - l0, 16'h3);
      repeat (2 * FRM) @(posedge clk);
      check(panel, 32'h0);
    end
    // override and hardware save, in both override settings
    cur_mode = 2'h0;
    dq.delete();
    wr(4'h3, 32'h1);
    wait_line(FRM);
    wr(4'h3, 32'h3);
    repeat (4) @(posedge clk);
    check(ppe, 1'b0);
    hps <= 1'b1;
    repeat (FRM + 8) @(posedge clk);
    check(panel, 32'h0);
    hps <= 1'b0;
    wait_line(FRM);
    check(ok, 1'b1);
    wr(4'h3, 32'h1);
    repeat (4) @(posedge clk);
    check(ppe, 1'b1);
    hps <= 1'b1;
    repeat (8) @(posedge clk);
    check(ppe, 1'b0);
    repeat (FRM) @(posedge clk);
    check(panel, 32'h0);
    hps <= 1'b0;
    repeat (8) @(posedge clk);
    check(ppe, 1'b1);
    wait_line(200);
    check(ok, 1'b1);
    tally_and_finish();
  end
endmodule : plcdt_timing_tb_top
